//--- pkg/eeprom_ctrl_pkg.sv
// holds register offsets, field layouts, reset values and timing defaults
// assumes a byte-wide register port and one 512-byte array behind it
package eeprom_ctrl_pkg;

	// ****************************************
	// register offsets
	// ****************************************
	localparam logic [3:0] OFF_PROGRAM_CONTROL = 4'h0;
	localparam logic [3:0] OFF_PROTECTION_CONFIG = 4'h1;
	localparam logic [3:0] OFF_PROTECTION_SHADOW = 4'h2;
	localparam logic [3:0] OFF_DIVISOR_HIGH = 4'h3;
	localparam logic [3:0] OFF_DIVISOR_LOW = 4'h4;
	localparam logic [3:0] OFF_DIVISOR_HIGH_SHADOW = 4'h5;
	localparam logic [3:0] OFF_DIVISOR_LOW_SHADOW = 4'h6;

	// ****************************************
	// array geometry
	// ****************************************
	localparam logic [15:0] ARRAY_BASE = 16'h0800;
	localparam int ARRAY_BYTES = 512;
	localparam int MEM_WORDS = 515;
	localparam logic [9:0] IDX_PROTECTION_SHADOW = 10'h200;
	localparam logic [9:0] IDX_DIVISOR_HIGH_SHADOW = 10'h201;
	localparam logic [9:0] IDX_DIVISOR_LOW_SHADOW = 10'h202;
	localparam logic [4:0] SECURED_ROW = 5'h0f;
	localparam logic [7:0] ERASED_BYTE = 8'hff;
	localparam logic [7:0] FACTORY_PROTECTION = 8'hf0;

	// ****************************************
	// field layouts and reset values
	// ****************************************
	typedef enum logic [1:0]
	{
		OP_BYTE_PROGRAM = 2'b00,
		OP_BYTE_ERASE = 2'b01,
		OP_BLOCK_ERASE = 2'b10,
		OP_BULK_ERASE = 2'b11
	} op_sel_t;

	typedef struct packed
	{
		logic spare;
		logic array_power_down;
		logic operation_select_hi;
		logic operation_select_lo;
		logic unused;
		logic latch_control;
		logic auto_terminate;
		logic charge_pump_enable;
	} ctrl_t;

	typedef struct packed
	{
		logic [2:0] spare;
		logic security_arm;
		logic [3:0] block_protect;
	} acr_t;

	localparam ctrl_t CTRL_RESET = 8'h00;
	localparam acr_t ACR_RESET = 8'hf0;
	localparam int DIV_LOCK_BIT = 7;
	localparam int DIV_HIGH_BITS = 3;
	localparam logic [10:0] DIVISOR_RESET = 11'h000;

	// ****************************************
	// timing
	// ****************************************
	localparam int TIMEBASE_US = 35;
	localparam logic [15:0] BYTE_PROGRAM_TICKS = 16'h0100;
	localparam logic [15:0] BYTE_ERASE_TICKS = 16'h0100;
	localparam logic [15:0] BLOCK_ERASE_TICKS = 16'h0100;
	localparam logic [15:0] BULK_ERASE_TICKS = 16'h0100;

	typedef enum logic [1:0]
	{
		ST_LOAD = 2'b00,
		ST_IDLE = 2'b01,
		ST_RUN = 2'b10,
		ST_HALT = 2'b11
	} seq_state_t;

endpackage

//--- rtl/timebase_divider.sv
// divides reference pulses by the loaded divisor into timebase ticks
// assumes ref_pulse is synchronous to core_clk, one pulse per reference cycle
`timescale 1ns/100ps
module timebase_divider
	import eeprom_ctrl_pkg::*;
#(
	parameter int DIV_WIDTH = 11
)
(
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic ref_pulse,
	input wire logic [DIV_WIDTH-1:0] divisor,
	output logic tick
);

	logic [DIV_WIDTH-1:0] count;
	logic [DIV_WIDTH-1:0] next_count;
	logic next_tick;
	logic wrap;

	// ****************************************
	// reference cycle counter
	// ****************************************
	always_comb
	begin
		next_count = count;
		next_tick = 1'b0;
		// a zero divisor behaves as one
		wrap = (count >= divisor - DIV_WIDTH'(1)) || (divisor == '0);
		if (ref_pulse)
		begin
			if (wrap)
			begin
				next_count = '0;
				next_tick = 1'b1;
			end
			else
			begin
				next_count = count + DIV_WIDTH'(1);
			end
		end
	end

	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			count <= '0;
			tick <= 1'b0;
		end
		else
		begin
			count <= next_count;
			tick <= next_tick;
		end
	end

endmodule

//--- rtl/eeprom_array_control_regs.sv
// program and erase control for one 512-byte array with its shadow bytes
// assumes a byte register port, a byte array port and synchronous mode inputs
`timescale 1ns/100ps
module eeprom_array_control_regs
	import eeprom_ctrl_pkg::*;
#(
	parameter logic [15:0] PROGRAM_TICKS = BYTE_PROGRAM_TICKS,
	parameter logic [15:0] ERASE_TICKS = BYTE_ERASE_TICKS,
	parameter logic [15:0] BLOCK_TICKS = BLOCK_ERASE_TICKS,
	parameter logic [15:0] BULK_TICKS = BULK_ERASE_TICKS
)
(
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic [15:0] array_addr,
	input wire logic [7:0] array_wdata,
	input wire logic array_wr,
	input wire logic array_rd,
	output logic [7:0] array_rdata,
	input wire logic ref_pulse,
	input wire logic wait_mode,
	input wire logic stop_mode,
	output logic high_voltage_on,
	output logic array_busy,
	output logic array_powered_down
);

	// ****************************************
	// helpers
	// ****************************************
	function automatic logic in_array(input logic [15:0] a);
		in_array = (a >= ARRAY_BASE) && (a < ARRAY_BASE + 16'(ARRAY_BYTES));
	endfunction

	// decides whether one stored byte is changed by the operation at target t
	function automatic logic may_modify(input logic [9:0] idx, input op_sel_t op, input logic [9:0] t,
		input acr_t acr_v, input logic lock_off);
		logic scope;
		logic allow;
		scope = 1'b0;
		allow = 1'b0;
		if (idx[9])
		begin
			scope = (idx == t) && (op == OP_BYTE_PROGRAM || op == OP_BYTE_ERASE);
			if (idx == IDX_PROTECTION_SHADOW)
				allow = acr_v.security_arm;
			else
				allow = lock_off;
		end
		else
		begin
			case (op)
				OP_BYTE_PROGRAM, OP_BYTE_ERASE: scope = (idx == t);
				OP_BLOCK_ERASE: scope = !t[9] && (idx[8:7] == t[8:7]);
				OP_BULK_ERASE: scope = !t[9];
				default: scope = 1'b0;
			endcase
			allow = !acr_v.block_protect[idx[8:7]];
			if (!acr_v.security_arm)
			begin
				if (idx[8:4] == SECURED_ROW)
					allow = 1'b0;
				if (op == OP_BLOCK_ERASE || op == OP_BULK_ERASE)
					allow = 1'b0;
			end
		end
		may_modify = scope && allow;
	endfunction

	// ****************************************
	// state
	// ****************************************
	logic [7:0] mem [MEM_WORDS];
	ctrl_t ctrl;
	ctrl_t next_ctrl;
	acr_t acr;
	acr_t next_acr;
	logic lock_off;
	logic next_lock_off;
	logic [10:0] divisor;
	logic [10:0] next_divisor;
	logic [9:0] target_idx;
	logic [9:0] next_target_idx;
	logic [7:0] target_data;
	logic [7:0] next_target_data;
	logic target_valid;
	logic next_target_valid;
	seq_state_t state;
	seq_state_t next_state;
	logic [15:0] tick_count;
	logic [15:0] next_tick_count;
	logic [7:0] next_reg_rdata;
	logic [7:0] next_array_rdata;
	logic apply;
	logic tick;
	ctrl_t wctrl;
	op_sel_t op;
	logic [15:0] duration;
	logic [9:0] array_idx;

	assign op = op_sel_t'({ctrl.operation_select_hi, ctrl.operation_select_lo});
	assign wctrl = ctrl_t'(reg_wdata);
	assign array_idx = 10'(array_addr - ARRAY_BASE);
	assign high_voltage_on = (state == ST_RUN);
	assign array_busy = (state == ST_RUN) || (state == ST_HALT);
	assign array_powered_down = ctrl.array_power_down;

	timebase_divider #(
		.DIV_WIDTH(11)
	) u_timebase (
		.core_clk(core_clk),
		.arst_n(arst_n),
		.ref_pulse(ref_pulse),
		.divisor(divisor),
		.tick(tick)
	);

	always_comb
	begin
		case (op)
			OP_BYTE_PROGRAM: duration = PROGRAM_TICKS;
			OP_BYTE_ERASE: duration = ERASE_TICKS;
			OP_BLOCK_ERASE: duration = BLOCK_TICKS;
			default: duration = BULK_TICKS;
		endcase
	end

	// ****************************************
	// control, configuration and sequence
	// ****************************************
	always_comb
	begin
		next_ctrl = ctrl;
		next_acr = acr;
		next_lock_off = lock_off;
		next_divisor = divisor;
		next_target_idx = target_idx;
		next_target_data = target_data;
		next_target_valid = target_valid;
		next_state = state;
		next_tick_count = tick_count;
		apply = 1'b0;
		if (state == ST_LOAD)
		begin
			next_acr = acr_t'(mem[IDX_PROTECTION_SHADOW]);
			next_lock_off = mem[IDX_DIVISOR_HIGH_SHADOW][DIV_LOCK_BIT];
			next_divisor = {mem[IDX_DIVISOR_HIGH_SHADOW][DIV_HIGH_BITS-1:0], mem[IDX_DIVISOR_LOW_SHADOW]};
			next_state = ST_IDLE;
		end
		else
		begin
			if (reg_wr)
			begin
				case (reg_addr)
					OFF_PROGRAM_CONTROL:
					begin
						next_ctrl.spare = wctrl.spare;
						next_ctrl.array_power_down = wctrl.array_power_down;
						next_ctrl.operation_select_hi = wctrl.operation_select_hi;
						next_ctrl.operation_select_lo = wctrl.operation_select_lo;
						next_ctrl.auto_terminate = wctrl.auto_terminate;
						if (!wctrl.charge_pump_enable)
							next_ctrl.charge_pump_enable = 1'b0;
						else if (!ctrl.charge_pump_enable && ctrl.latch_control && target_valid)
							next_ctrl.charge_pump_enable = 1'b1;
						if (wctrl.latch_control || !ctrl.charge_pump_enable)
							next_ctrl.latch_control = wctrl.latch_control;
					end
					OFF_PROTECTION_CONFIG:
						next_acr.spare = reg_wdata[7:5];
					OFF_DIVISOR_HIGH:
						if (!ctrl.latch_control && lock_off)
						begin
							next_lock_off = reg_wdata[DIV_LOCK_BIT];
							next_divisor[10:8] = reg_wdata[DIV_HIGH_BITS-1:0];
						end
					OFF_DIVISOR_LOW:
						if (!ctrl.latch_control && lock_off)
							next_divisor[7:0] = reg_wdata;
					OFF_PROTECTION_SHADOW:
						if (ctrl.latch_control && !array_busy)
						begin
							next_target_idx = IDX_PROTECTION_SHADOW;
							next_target_data = reg_wdata;
							next_target_valid = 1'b1;
						end
					OFF_DIVISOR_HIGH_SHADOW:
						if (ctrl.latch_control && !array_busy)
						begin
							next_target_idx = IDX_DIVISOR_HIGH_SHADOW;
							next_target_data = reg_wdata;
							next_target_valid = 1'b1;
						end
					OFF_DIVISOR_LOW_SHADOW:
						if (ctrl.latch_control && !array_busy)
						begin
							next_target_idx = IDX_DIVISOR_LOW_SHADOW;
							next_target_data = reg_wdata;
							next_target_valid = 1'b1;
						end
					default:
					begin
					end
				endcase
			end
			// array port: only valid addresses are taken while latching
			if (ctrl.latch_control && !array_busy && in_array(array_addr))
			begin
				if (array_wr)
				begin
					next_target_idx = array_idx;
					next_target_data = array_wdata;
					next_target_valid = 1'b1;
				end
				else if (array_rd)
				begin
					next_target_idx = array_idx;
					next_target_valid = 1'b1;
				end
			end
			if (!next_ctrl.latch_control)
				next_target_valid = 1'b0;
			// sequence; wait_mode has no say here
			case (state)
				ST_IDLE:
					if (next_ctrl.charge_pump_enable && !ctrl.charge_pump_enable)
					begin
						next_state = ST_RUN;
						next_tick_count = '0;
					end
				ST_RUN:
				begin
					if (stop_mode)
					begin
						if (ctrl.latch_control && ctrl.charge_pump_enable)
							next_state = ST_HALT;
						else
							next_state = ST_IDLE;
						next_tick_count = '0;
					end
					else if (!next_ctrl.charge_pump_enable)
						next_state = ST_IDLE;
					else if (tick)
					begin
						if (tick_count + 16'h0001 >= duration)
						begin
							apply = 1'b1;
							next_state = ST_IDLE;
							if (ctrl.auto_terminate)
								next_ctrl.charge_pump_enable = 1'b0;
						end
						else
							next_tick_count = tick_count + 16'h0001;
					end
				end
				ST_HALT:
					if (!stop_mode)
					begin
						next_state = ST_RUN;
						next_tick_count = '0;
					end
				default:
					next_state = ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			ctrl <= CTRL_RESET;
			acr <= ACR_RESET;
			lock_off <= 1'b0;
			divisor <= DIVISOR_RESET;
			target_idx <= '0;
			target_data <= '0;
			target_valid <= 1'b0;
			state <= ST_LOAD;
			tick_count <= '0;
		end
		else
		begin
			ctrl <= next_ctrl;
			acr <= next_acr;
			lock_off <= next_lock_off;
			divisor <= next_divisor;
			target_idx <= next_target_idx;
			target_data <= next_target_data;
			target_valid <= next_target_valid;
			state <= next_state;
			tick_count <= next_tick_count;
		end
	end

	// ****************************************
	// storage array and shadow bytes
	// ****************************************
	// no reset and a plain always: contents are loaded from outside before use
	always @(posedge core_clk)
	begin
		if (apply)
		begin
			for (int i = 0; i < MEM_WORDS; i++)
			begin
				if (may_modify(10'(i), op, target_idx, acr, lock_off))
				begin
					if (op == OP_BYTE_PROGRAM)
						mem[i] <= mem[i] & target_data;
					else
						mem[i] <= ERASED_BYTE;
				end
			end
		end
	end

	// ****************************************
	// read paths
	// ****************************************
	always_comb
	begin
		next_reg_rdata = 8'h00;
		if (reg_rd)
		begin
			case (reg_addr)
				OFF_PROGRAM_CONTROL: next_reg_rdata = {ctrl[7:4], 1'b0, ctrl[2:0]};
				OFF_PROTECTION_CONFIG: next_reg_rdata = acr;
				OFF_PROTECTION_SHADOW: next_reg_rdata = mem[IDX_PROTECTION_SHADOW];
				OFF_DIVISOR_HIGH: next_reg_rdata = {lock_off, 4'h0, divisor[10:8]};
				OFF_DIVISOR_LOW: next_reg_rdata = divisor[7:0];
				OFF_DIVISOR_HIGH_SHADOW: next_reg_rdata = mem[IDX_DIVISOR_HIGH_SHADOW];
				OFF_DIVISOR_LOW_SHADOW: next_reg_rdata = mem[IDX_DIVISOR_LOW_SHADOW];
				default: next_reg_rdata = 8'h00;
			endcase
		end
		next_array_rdata = 8'h00;
		if (array_rd && in_array(array_addr))
		begin
			if (ctrl.array_power_down || array_busy)
				next_array_rdata = ERASED_BYTE;
			else if (ctrl.latch_control)
				next_array_rdata = target_data;
			else
				next_array_rdata = mem[array_idx[8:0]];
		end
	end

	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			reg_rdata <= 8'h00;
			array_rdata <= 8'h00;
		end
		else
		begin
			reg_rdata <= next_reg_rdata;
			array_rdata <= next_array_rdata;
		end
	end

endmodule

//--- test/eeprom_array_control_regs_properties.sv
// checker for the program and erase control block, top-level ports only
// assumes one clock domain and bind from the testbench top file
`timescale 1ns/100ps
module eeprom_array_control_regs_properties
	import eeprom_ctrl_pkg::*;
(
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic [15:0] array_addr,
	input wire logic array_rd,
	input wire logic [7:0] array_rdata,
	input wire logic stop_mode,
	input wire logic high_voltage_on,
	input wire logic array_busy,
	input wire logic array_powered_down
);
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!arst_n);
	wire logic ctrl_sel = reg_addr == OFF_PROGRAM_CONTROL;
	wire logic in_rng = array_addr[15:9] == 7'h04;
	sequence latch_only_wr;
		reg_wr && ctrl_sel && reg_wdata[2] && !reg_wdata[0];
	endsequence
	sequence both_clear_wr;
		reg_wr && ctrl_sel && reg_wdata[2:0] == 3'b000 && high_voltage_on;
	endsequence
	sequence ctrl_rd;
		reg_rd && !reg_wr && ctrl_sel;
	endsequence
	AST_CTRL_KEEP: assert property (latch_only_wr ##1 !reg_wr ##1 ctrl_rd |=> reg_rdata == ($past(reg_wdata, 3) & 8'hf7))
		else $error("control readback differs");
	AST_BOTH_CLEAR: assert property (both_clear_wr ##1 !reg_wr ##1 ctrl_rd |=> reg_rdata[2:0] == 3'b100)
		else $error("latch lost with pump clear");
	AST_HV_BUSY: assert property (high_voltage_on |-> array_busy)
		else $error("high voltage while idle");
	AST_HV_CAUSE: assert property ($rose(high_voltage_on) |-> ($past(reg_wr) && $past(ctrl_sel) && $past(reg_wdata[0])) || $past(stop_mode) || $past(stop_mode, 2))
		else $error("high voltage without pump write");
	AST_STOP_HV: assert property (stop_mode |=> !high_voltage_on)
		else $error("high voltage kept in stop");
	AST_HALT_BUSY: assert property (stop_mode && array_busy |=> array_busy)
		else $error("halted sequence lost");
	AST_BLOCKED_READ: assert property (array_rd && in_rng && (array_busy || array_powered_down) |=> array_rdata == 8'hff)
		else $error("blocked read returned data");
	AST_RD_IDLE: assert property (!reg_rd |=> reg_rdata == 8'h00)
		else $error("register data outside read slot");
	AST_ARD_IDLE: assert property (!array_rd |=> array_rdata == 8'h00)
		else $error("array data outside read slot");
	AST_PD_SET: assert property (reg_wr && ctrl_sel |=> array_powered_down == $past(reg_wdata[6]))
		else $error("power-down not following write");
	AST_PD_HOLD: assert property (!(reg_wr && ctrl_sel) |=> $stable(array_powered_down))
		else $error("power-down changed alone");
endmodule

//--- test/eeprom_array_control_regs_test.sv
// self-checking bench with a byte-level reference model of the array
// assumes the block exposes its storage as mem for preloading
`timescale 1ns/100ps
module eeprom_array_control_regs_test;
	import eeprom_ctrl_pkg::*;
	logic core_clk = 1'b0;
	logic arst_n = 1'b0;
	logic [3:0] reg_addr = 4'h0;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [7:0] reg_rdata;
	logic [15:0] array_addr = 16'h0000;
	logic [7:0] array_wdata = 8'h00;
	logic array_wr = 1'b0;
	logic array_rd = 1'b0;
	logic [7:0] array_rdata;
	logic ref_pulse = 1'b1;
	logic wait_mode = 1'b0;
	logic stop_mode = 1'b0;
	logic high_voltage_on;
	logic array_busy;
	logic array_powered_down;
	logic [7:0] v;
	logic [7:0] cfg = 8'hf0;
	int num_errors = 0;
	int checked = 0;
	int mdl[515];
	int t_idx[5] = '{3, 245, 260, 260, 512};
	logic [1:0] t_op[5] = '{2'b00, 2'b00, 2'b00, 2'b10, 2'b01};
	int n;
	int a;
	eeprom_array_control_regs #(.PROGRAM_TICKS(16'h0003), .ERASE_TICKS(16'h0003), .BLOCK_TICKS(16'h0003),
		.BULK_TICKS(16'h0003)) u_dut (.core_clk(core_clk), .arst_n(arst_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .array_addr(array_addr),
		.array_wdata(array_wdata), .array_wr(array_wr), .array_rd(array_rd), .array_rdata(array_rdata),
		.ref_pulse(ref_pulse), .wait_mode(wait_mode), .stop_mode(stop_mode), .high_voltage_on(high_voltage_on),
		.array_busy(array_busy), .array_powered_down(array_powered_down));
	initial
	begin
		forever #2.5 core_clk = ~core_clk;
	end
	// random reference pulses keep the timebase phase moving
	always @(posedge core_clk)
	begin
		ref_pulse <= 1'($urandom);
	end
	// ****
	// drivers and model
	// ****
	task automatic test_done();
		$display("checks %0d errors %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic rw(input logic [3:0] ad, input logic [7:0] d);
		@(posedge core_clk);
		reg_addr <= ad;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rc(input logic [3:0] ad, input logic [7:0] e);
		@(posedge core_clk);
		reg_addr <= ad;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata, e);
	endtask
	task automatic acc(input logic w, input int idx, input logic [7:0] d);
		@(posedge core_clk);
		array_addr <= ARRAY_BASE + 16'(idx);
		array_wdata <= d;
		array_wr <= w;
		array_rd <= !w;
		@(posedge core_clk);
		array_wr <= 1'b0;
		array_rd <= 1'b0;
		#1 v = array_rdata;
	endtask
	task automatic rst();
		arst_n <= 1'b0;
		repeat (10) @(posedge core_clk);
		arst_n <= 1'b1;
		repeat (2) @(posedge core_clk);
	endtask
	task automatic idle();
		int k;
		for (k = 0; k < 400; k++)
		begin
			@(posedge core_clk);
			#1;
			if (array_busy === 1'b0)
				break;
		end
		if (k == 400)
		begin
			num_errors++;
			test_done();
		end
	endtask
	function automatic void mop(input logic [1:0] m, input int idx, input logic [7:0] d);
		int lo;
		int hi;
		lo = (m == 2'b11) ? 0 : (m == 2'b10) ? (idx & ~127) : idx;
		hi = (m == 2'b11) ? 511 : (m == 2'b10) ? lo + 127 : idx;
		if ((m[1] && !cfg[4]) || (idx >= 512 && (m[1] || (idx == 512 && !cfg[4]))))
			return;
		for (int j = lo; j <= hi; j++)
			if (j >= 512 || (!cfg[j / 128] && !(!cfg[4] && j >= 240 && j < 256)))
				mdl[j] = (m == 2'b00) ? (mdl[j] & d) : 255;
	endfunction
	task automatic op(input logic [1:0] m, input int idx, input logic [7:0] d, input logic stp);
		rw(OFF_PROGRAM_CONTROL, {2'b00, m, 4'b0110});
		if (idx >= 512)
			rw(idx == 512 ? OFF_PROTECTION_SHADOW : OFF_DIVISOR_HIGH_SHADOW, d);
		else
			acc(1'b1, idx, d);
		rw(OFF_PROGRAM_CONTROL, {2'b00, m, 4'b0111});
		if (stp)
		begin
			stop_mode <= 1'b1;
			acc(1'b0, idx, 8'h00);
			chk(v, 8'hff);
			chk({6'h00, high_voltage_on, array_busy}, 8'h01);
			@(posedge core_clk);
			stop_mode <= 1'b0;
		end
		idle();
		rc(OFF_PROGRAM_CONTROL, {2'b00, m, 4'b0110});
		rw(OFF_PROGRAM_CONTROL, 8'h00);
		mop(m, idx, d);
	endtask
	// ****
	// main sequence
	// ****
	initial
	begin
		v = 8'($urandom(37512));
		for (n = 0; n < 515; n++)
			mdl[n] = (n == 512) ? 8'hf0 : (n == 513) ? 8'h80 : (n == 514) ? 8'h00 : 8'hff;
		for (n = 0; n < 515; n++)
			u_dut.mem[n] = 8'(mdl[n]);
		rst();
		rc(OFF_PROGRAM_CONTROL, 8'h00);
		rc(OFF_PROTECTION_CONFIG, 8'hf0);
		rc(OFF_DIVISOR_HIGH, 8'h80);
		rc(OFF_DIVISOR_LOW, 8'h00);
		rc(4'hf, 8'h00);
		$display("test 1 end");
		rw(OFF_PROGRAM_CONTROL, 8'h84);
		rc(OFF_PROGRAM_CONTROL, 8'h84);
		rw(OFF_DIVISOR_LOW, 8'h09);
		rc(OFF_DIVISOR_LOW, 8'h00);
		rw(OFF_PROGRAM_CONTROL, 8'h05);
		rc(OFF_PROGRAM_CONTROL, 8'h04);
		rw(OFF_PROGRAM_CONTROL, 8'h41);
		rc(OFF_PROGRAM_CONTROL, 8'h40);
		chk({7'h00, array_powered_down}, 8'h01);
		acc(1'b0, 5, 8'h00);
		chk(v, 8'hff);
		rw(OFF_PROGRAM_CONTROL, 8'h00);
		rw(OFF_DIVISOR_LOW, 8'h08);
		rc(OFF_DIVISOR_LOW, 8'h08);
		rw(OFF_PROTECTION_CONFIG, 8'h0f);
		rc(OFF_PROTECTION_CONFIG, 8'h10);
		$display("test 2 end");
		for (n = 0; n < 12; n++)
		begin
			a = $urandom_range(0, 511);
			wait_mode <= 1'(n % 2);
			op(2'(n % 4), a, 8'($urandom), n == 5);
			acc(1'b0, a, 8'h00);
			chk(v, 8'(mdl[a]));
			acc(1'b0, a ^ 1, 8'h00);
			chk(v, 8'(mdl[a ^ 1]));
		end
		$display("test 3 end");
		rw(OFF_PROGRAM_CONTROL, 8'h04);
		acc(1'b1, 300, 8'h5a);
		acc(1'b0, 300, 8'h00);
		chk(v, 8'h5a);
		rw(OFF_PROGRAM_CONTROL, 8'h05);
		rw(OFF_PROGRAM_CONTROL, 8'h00);
		rc(OFF_PROGRAM_CONTROL, 8'h04);
		rw(OFF_PROGRAM_CONTROL, 8'h00);
		rc(OFF_PROGRAM_CONTROL, 8'h00);
		acc(1'b0, 300, 8'h00);
		chk(v, 8'(mdl[300]));
		$display("test 4 end");
		op(2'b00, 512, 8'he1, 1'b0);
		rst();
		cfg = 8'(mdl[512]);
		rc(OFF_PROTECTION_CONFIG, cfg);
		for (n = 0; n < 5; n++)
		begin
			a = t_idx[n];
			op(t_op[n], a, 8'h00, 1'b0);
			if (a == 512)
				rc(OFF_PROTECTION_SHADOW, 8'(mdl[512]));
			else
			begin
				acc(1'b0, a, 8'h00);
				chk(v, 8'(mdl[a]));
			end
		end
		$display("test 5 end");
		op(2'b00, 513, 8'h00, 1'b0);
		rst();
		rw(OFF_DIVISOR_LOW, 8'h07);
		rc(OFF_DIVISOR_HIGH, 8'h00);
		rc(OFF_DIVISOR_LOW, 8'h00);
		$display("test 6 end");
		test_done();
	end
endmodule
bind eeprom_array_control_regs eeprom_array_control_regs_properties u_props (.core_clk(core_clk), .arst_n(arst_n),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.array_addr(array_addr), .array_rd(array_rd), .array_rdata(array_rdata), .stop_mode(stop_mode),
	.high_voltage_on(high_voltage_on), .array_busy(array_busy), .array_powered_down(array_powered_down));
